// File: hdl/amrc_pkg.sv
// constants and types for the converter mode and reset control block
package amrc_pkg;

   // ----------------------------------------
   // sampling modes (high pin first)
   // ----------------------------------------
   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_DOUBLE = 2'h1;
   localparam logic [1:0] MODE_QUAD = 2'h2;
   localparam logic [1:0] MODE_RSVD = 2'h3;

   // ----------------------------------------
   // per-mode ratios
   // ----------------------------------------
   localparam logic [7:0] OSR_NORMAL = 8'h80;
   localparam logic [7:0] OSR_DOUBLE = 8'h40;
   localparam logic [7:0] OSR_QUAD = 8'h20;
   localparam logic [8:0] MCK_NORMAL = 9'h100;
   localparam logic [8:0] MCK_DOUBLE = 9'h080;
   localparam logic [8:0] MCK_QUAD = 9'h040;
   // master clock edges per bit clock half period (ratio / 64)
   localparam logic [2:0] HALF_NORMAL = 3'h4;
   localparam logic [2:0] HALF_DOUBLE = 3'h2;
   localparam logic [2:0] HALF_QUAD = 3'h1;

   // ----------------------------------------
   // word length codes and bits dropped
   // ----------------------------------------
   localparam logic [1:0] WL_24 = 2'h0;
   localparam logic [1:0] WL_18 = 2'h1;
   localparam logic [1:0] WL_20 = 2'h2;
   localparam logic [1:0] WL_16 = 2'h3;
   localparam logic [3:0] DROP_24 = 4'h0;
   localparam logic [3:0] DROP_18 = 4'h6;
   localparam logic [3:0] DROP_20 = 4'h4;
   localparam logic [3:0] DROP_16 = 4'h8;

   // ----------------------------------------
   // framing, timing, reset values
   // ----------------------------------------
   localparam int SAMPLE_W = 24;
   localparam logic [5:0] LAST_BIT = 6'h3F;
   localparam logic [10:0] INIT_CYCLES = 11'h400;
   localparam logic [15:0] LFSR_SEED = 16'hACE1;
   localparam logic [23:0] SAT_POS = 24'h7FFFFF;

   typedef enum logic [1:0] {ST_PWRDN, ST_INIT, ST_RUN, ST_HALT} amrc_state_t;

   typedef struct packed {
      logic [1:0] mode;
      logic low_delay;
      logic [1:0] wl;
   } amrc_cfg_t;

endpackage

// File: hdl/amrc_top.sv
// sampling-mode decode, reset/power-down and serial port clocking
`timescale 1ns/1ns
module amrc_top import amrc_pkg::*; (
   // clock and reset
   input wire logic CLK_SYS_IN,
   input wire logic RSTN_IN,
   // master clock level, sampled
   input wire logic MASTER_CLOCK_IN,
   // static control pins
   input wire logic RATE_MODE_SEL_HI_IN,
   input wire logic RATE_MODE_SEL_LO_IN,
   input wire logic FILTER_RESPONSE_SEL_IN,
   input wire logic [1:0] WORD_LEN_SEL_IN,
   input wire logic SAMPLE_OUTPUT_ENABLE_IN,
   // samples from the decimator
   input wire logic [23:0] SAMPLE_LEFT_IN,
   input wire logic [23:0] SAMPLE_RIGHT_IN,
   // serial port
   output logic DATA_OUT,
   output logic BCK_OUT,
   output logic LRCK_OUT,
   output logic SAMPLE_TAKE_OUT,
   // status and mode settings
   output logic POWER_DOWN_OUT,
   output logic INIT_BUSY_OUT,
   output logic MODE_ERR_OUT,
   output logic [1:0] MODE_OUT,
   output logic [7:0] OSR_OUT,
   output logic [8:0] MCK_RATIO_OUT,
   output logic LOW_DELAY_FILT_OUT
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [23:0] reduce(input logic [23:0] s, input logic [1:0] wl,
                                          input logic [15:0] rnd);
      logic [3:0] drop;
      logic [23:0] mask;
      logic [24:0] sum;
      logic [23:0] r;
      unique case (wl)
         WL_18: drop = DROP_18;
         WL_20: drop = DROP_20;
         WL_16: drop = DROP_16;
         WL_24: drop = DROP_24;
      endcase
      mask = ~(24'hFFFFFF << drop);
      sum = {1'h0, s} + {1'h0, {8'h00, rnd} & mask};
      // adding a non-negative dither can only overflow upward
      if (!s[23] && sum[23]) begin
         r = SAT_POS;
      end else begin
         r = sum[23:0];
      end
      return r & ~mask;
   endfunction

   // ----------------------------------------
   // reset synchroniser
   // ----------------------------------------
   logic rst_s1_q;
   logic rst_n;

   always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         rst_s1_q <= 1'h0;
         rst_n <= 1'h0;
      end else begin
         rst_s1_q <= 1'h1;
         rst_n <= rst_s1_q;
      end
   end

   // ----------------------------------------
   // control state
   // ----------------------------------------
   amrc_state_t state_q, state_d;
   amrc_cfg_t cfg_q, cfg_d;
   logic [10:0] init_cnt_q, init_cnt_d;
   logic pd_d, busy_d, err_d, lowd_d;
   logic [7:0] osr_d;
   logic [8:0] mck_d;

   always_comb begin
      state_d = state_q;
      cfg_d = cfg_q;
      init_cnt_d = init_cnt_q;
      unique case (state_q)
         ST_PWRDN: begin
            cfg_d.mode = {RATE_MODE_SEL_HI_IN, RATE_MODE_SEL_LO_IN};
            cfg_d.low_delay = FILTER_RESPONSE_SEL_IN;
            cfg_d.wl = WORD_LEN_SEL_IN;
            if (cfg_d.mode == MODE_QUAD) begin
               cfg_d.low_delay = 1'h1;
            end
            init_cnt_d = 11'h000;
            state_d = ST_INIT;
         end
         ST_INIT: begin
            init_cnt_d = init_cnt_q + 11'h001;
            if (init_cnt_q == INIT_CYCLES - 11'h001) begin
               state_d = (cfg_q.mode == MODE_RSVD) ? ST_HALT : ST_RUN;
            end
         end
         ST_RUN: state_d = ST_RUN;
         ST_HALT: state_d = ST_HALT;
      endcase
      pd_d = 1'h0;
      busy_d = (state_d == ST_INIT);
      err_d = (state_d == ST_HALT);
      lowd_d = cfg_d.low_delay;
      unique case (cfg_d.mode)
         MODE_DOUBLE: begin
            osr_d = OSR_DOUBLE;
            mck_d = MCK_DOUBLE;
         end
         MODE_QUAD: begin
            osr_d = OSR_QUAD;
            mck_d = MCK_QUAD;
         end
         default: begin
            osr_d = OSR_NORMAL;
            mck_d = MCK_NORMAL;
         end
      endcase
   end

   always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_PWRDN;
         cfg_q <= '0;
         init_cnt_q <= 11'h000;
         POWER_DOWN_OUT <= 1'h1;
         INIT_BUSY_OUT <= 1'h0;
         MODE_ERR_OUT <= 1'h0;
         MODE_OUT <= MODE_NORMAL;
         OSR_OUT <= 8'h00;
         MCK_RATIO_OUT <= 9'h000;
         LOW_DELAY_FILT_OUT <= 1'h0;
      end else begin
         state_q <= state_d;
         cfg_q <= cfg_d;
         init_cnt_q <= init_cnt_d;
         POWER_DOWN_OUT <= pd_d;
         INIT_BUSY_OUT <= busy_d;
         MODE_ERR_OUT <= err_d;
         MODE_OUT <= cfg_d.mode;
         OSR_OUT <= osr_d;
         MCK_RATIO_OUT <= mck_d;
         LOW_DELAY_FILT_OUT <= lowd_d;
      end
   end

   // ----------------------------------------
   // serial port clocking and data
   // ----------------------------------------
   logic mck_q, mck_d2;
   logic [2:0] edge_cnt_q, edge_cnt_d;
   logic [5:0] bit_cnt_q, bit_cnt_d;
   logic [63:0] sh_q, sh_d;
   logic [15:0] lfsr_q, lfsr_d;
   logic bck_d, lrck_d, take_d;
   logic active;
   logic [2:0] half;

   always_comb begin
      mck_d2 = MASTER_CLOCK_IN;
      // outputs low unless running and enabled
      active = (state_q == ST_RUN) && SAMPLE_OUTPUT_ENABLE_IN;
      unique case (cfg_q.mode)
         MODE_DOUBLE: half = HALF_DOUBLE;
         MODE_QUAD: half = HALF_QUAD;
         default: half = HALF_NORMAL;
      endcase
      edge_cnt_d = edge_cnt_q;
      bit_cnt_d = bit_cnt_q;
      sh_d = sh_q;
      lfsr_d = lfsr_q;
      bck_d = BCK_OUT;
      take_d = 1'h0;
      if (!active) begin
         edge_cnt_d = 3'h0;
         bit_cnt_d = LAST_BIT;
         sh_d = '0;
         bck_d = 1'h0;
      end else if (mck_q != MASTER_CLOCK_IN) begin
         if (edge_cnt_q == half - 3'h1) begin
            edge_cnt_d = 3'h0;
            bck_d = ~BCK_OUT;
            if (BCK_OUT) begin
               // data changes on falling bit clock
               bit_cnt_d = bit_cnt_q + 6'h01;
               if (bit_cnt_q == LAST_BIT) begin
                  sh_d = {reduce(SAMPLE_LEFT_IN, cfg_q.wl, lfsr_q), 8'h00,
                          reduce(SAMPLE_RIGHT_IN, cfg_q.wl, {lfsr_q[7:0], lfsr_q[15:8]}),
                          8'h00};
                  lfsr_d = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
                  take_d = 1'h1;
               end else begin
                  sh_d = {sh_q[62:0], 1'h0};
               end
            end
         end else begin
            edge_cnt_d = edge_cnt_q + 3'h1;
         end
      end
      // left slot while word clock high
      lrck_d = active & ~bit_cnt_d[5];
   end

   always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
      if (!rst_n) begin
         mck_q <= 1'h0;
         edge_cnt_q <= 3'h0;
         bit_cnt_q <= LAST_BIT;
         sh_q <= '0;
         lfsr_q <= LFSR_SEED;
         BCK_OUT <= 1'h0;
         LRCK_OUT <= 1'h0;
         DATA_OUT <= 1'h0;
         SAMPLE_TAKE_OUT <= 1'h0;
      end else begin
         mck_q <= mck_d2;
         edge_cnt_q <= edge_cnt_d;
         bit_cnt_q <= bit_cnt_d;
         sh_q <= sh_d;
         lfsr_q <= lfsr_d;
         BCK_OUT <= bck_d;
         LRCK_OUT <= lrck_d;
         DATA_OUT <= active & sh_d[63];
         SAMPLE_TAKE_OUT <= take_d;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_init_after_release;
      @(posedge CLK_SYS_IN) $rose(rst_n) |-> ##[1:2] INIT_BUSY_OUT;
   endproperty
   a_init_after_release: assert property (p_init_after_release) else $error("no init");

   property p_no_power_down;
      @(posedge CLK_SYS_IN) disable iff (!rst_n) $past(rst_n) |-> !POWER_DOWN_OUT;
   endproperty
   a_no_power_down: assert property (p_no_power_down) else $error("power-down stuck");

   property p_quiet_init;
      @(posedge CLK_SYS_IN) disable iff (!rst_n)
         INIT_BUSY_OUT |-> !DATA_OUT && !BCK_OUT && !LRCK_OUT;
   endproperty
   a_quiet_init: assert property (p_quiet_init) else $error("port active in init");

   property p_enable_low;
      @(posedge CLK_SYS_IN) disable iff (!rst_n)
         !SAMPLE_OUTPUT_ENABLE_IN |=> !DATA_OUT && !BCK_OUT && !LRCK_OUT;
   endproperty
   a_enable_low: assert property (p_enable_low) else $error("port active while disabled");

   property p_wl16;
      @(posedge CLK_SYS_IN) disable iff (!rst_n)
         SAMPLE_TAKE_OUT && cfg_q.wl == WL_16 |-> sh_q[47:40] == 8'h00;
   endproperty
   a_wl16: assert property (p_wl16) else $error("16-bit word not truncated");

   property p_no_reserved_run;
      @(posedge CLK_SYS_IN) disable iff (!rst_n) state_q == ST_RUN |-> MODE_OUT != MODE_RSVD;
   endproperty
   a_no_reserved_run: assert property (p_no_reserved_run) else $error("reserved mode ran");

   property p_normal_ratio;
      @(posedge CLK_SYS_IN) disable iff (!rst_n) state_q == ST_RUN && MODE_OUT == MODE_NORMAL
         |-> OSR_OUT == 8'h80 && MCK_RATIO_OUT == 9'h100;
   endproperty
   a_normal_ratio: assert property (p_normal_ratio) else $error("normal ratios wrong");

   property p_double_ratio;
      @(posedge CLK_SYS_IN) disable iff (!rst_n) MODE_OUT == MODE_DOUBLE && !INIT_BUSY_OUT
         |-> OSR_OUT == 8'h40 && MCK_RATIO_OUT == 9'h080;
   endproperty
   a_double_ratio: assert property (p_double_ratio) else $error("double ratios wrong");

   property p_quad_ratio;
      @(posedge CLK_SYS_IN) disable iff (!rst_n) MODE_OUT == MODE_QUAD
         |-> OSR_OUT == 8'h20 && MCK_RATIO_OUT == 9'h040 && LOW_DELAY_FILT_OUT;
   endproperty
   a_quad_ratio: assert property (p_quad_ratio) else $error("quad settings wrong");

   property p_lrck_on_fall;
      @(posedge CLK_SYS_IN) disable iff (!rst_n)
         $changed(LRCK_OUT) && $past(active) && active |-> $fell(BCK_OUT);
   endproperty
   a_lrck_on_fall: assert property (p_lrck_on_fall) else $error("word clock off edge");

   property p_cfg_static;
      @(posedge CLK_SYS_IN) disable iff (!rst_n) state_q != ST_PWRDN |=> $stable(cfg_q);
   endproperty
   a_cfg_static: assert property (p_cfg_static) else $error("config changed");

endmodule

// File: verif/amrc_mclk_src.sv
// master clock source model for the mode and reset control bench
`timescale 1ns/1ns
module amrc_mclk_src (
   // clock and run request
   input wire logic clk_in,
   input wire logic run_in,
   // master clock level
   output logic mclk_out
);
   logic ph_q = 1'b0;
   initial mclk_out = 1'b0;
   // steady clock before release
   // toggles every second cycle: the block needs master below half the system rate
   always @(negedge clk_in) begin
      ph_q <= run_in ? ~ph_q : 1'b0;
      mclk_out <= (run_in && ph_q) ? ~mclk_out : (run_in ? mclk_out : 1'b0);
   end
endmodule

// File: verif/adc_mode_reset_control_tb.sv
// self-checking bench for the mode and reset control block
`timescale 1ns/1ns
module adc_mode_reset_control_tb import amrc_pkg::*; ();
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic run = 1'b1;
   logic sel_hi = 1'b0, sel_lo = 1'b0, df = 1'b0, en = 1'b0, busy_q = 1'b0;
   logic [1:0] wl = 2'h0;
   logic [23:0] left = 24'h0, right = 24'h0;
   logic mclk, data, bck, lrck, take, pdn, busy, merr, ldf;
   logic [1:0] mode;
   logic [7:0] osr;
   logic [8:0] mck;
   logic [31:0] seed = 32'h2E10;
   int mismatches = 0, tests_run = 0, cycles = 0, words = 0;
   logic [19:0] mq[$];
   logic [51:0] wq[$];

   always #25 clk = ~clk;

   amrc_mclk_src u_src (.clk_in(clk), .run_in(run), .mclk_out(mclk));

   amrc_top u_dut (.CLK_SYS_IN(clk), .RSTN_IN(rst_n), .MASTER_CLOCK_IN(mclk),
      .RATE_MODE_SEL_HI_IN(sel_hi), .RATE_MODE_SEL_LO_IN(sel_lo),
      .FILTER_RESPONSE_SEL_IN(df), .WORD_LEN_SEL_IN(wl), .SAMPLE_OUTPUT_ENABLE_IN(en),
      .SAMPLE_LEFT_IN(left), .SAMPLE_RIGHT_IN(right), .DATA_OUT(data), .BCK_OUT(bck),
      .LRCK_OUT(lrck), .SAMPLE_TAKE_OUT(take), .POWER_DOWN_OUT(pdn),
      .INIT_BUSY_OUT(busy), .MODE_ERR_OUT(merr), .MODE_OUT(mode), .OSR_OUT(osr),
      .MCK_RATIO_OUT(mck), .LOW_DELAY_FILT_OUT(ldf));

   // ----------------------------------------
   // helpers and compare tasks
   // ----------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [19:0] exp_mode(input logic [1:0] m, input logic d);
      case (m)
         MODE_NORMAL: return {m, OSR_NORMAL, MCK_NORMAL, d};
         MODE_DOUBLE: return {m, OSR_DOUBLE, MCK_DOUBLE, d};
         default: return {m, OSR_QUAD, MCK_QUAD, 1'b1};
      endcase
   endfunction

   // dropped low bits for each word length code
   function automatic logic [23:0] drop_mask(input logic [1:0] w);
      case (w)
         // 16, 18 or 20 bits kept
         WL_16: return 24'h0000FF;
         WL_18: return 24'h00003F;
         WL_20: return 24'h00000F;
         default: return 24'h000000;
      endcase
   endfunction

   // dither stays below one kept lsb; top positive code can only saturate
   function automatic logic within_lsb(input logic [23:0] s, input logic [23:0] g,
                                       input logic [23:0] dm);
      logic [23:0] t;
      t = s & ~dm;
      return (g === t) || (g === t + dm + 24'h000001 && t != (24'h7FFFFF & ~dm));
   endfunction

   // cycles from frame start to the 63rd bit clock fall, master edges 2 cycles apart
   function automatic logic [15:0] bck_len(input logic [1:0] m);
      logic [8:0] r;
      case (m)
         MODE_DOUBLE: r = MCK_DOUBLE;
         MODE_QUAD: r = MCK_QUAD;
         default: r = MCK_NORMAL;
      endcase
      return ({7'h00, r} >> 4) * 16'h003F;
   endfunction

   task automatic check_cnt(input string what, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("FAIL %s expected %0d seen %0d", what, e, g);
      end
   endtask

   task automatic check_mode(input string what, input logic [19:0] e, input logic [19:0] g);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic check_word(input string what, input logic [23:0] e, input logic [23:0] g);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic check_lvl(input string what, input logic e, input logic g);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("FAIL %s expected %b seen %b", what, e, g);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // reset with given pins, then flip the mode and filter pins once latched to show they are ignored
   task automatic do_reset(input logic [1:0] m, input logic d, input logic [1:0] w);
      int k;
      @(negedge clk);
      rst_n = 1'b0;
      en = 1'b0;
      {sel_hi, sel_lo} = m;
      df = d;
      wl = w;
      repeat (4) @(negedge clk);
      check_lvl("power down", 1'b1, pdn);
      check_lvl("port in reset", 1'b0, data | bck | lrck);
      if (m != MODE_RSVD)
         mq.push_back(exp_mode(m, d));
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      check_lvl("initializing", 1'b1, busy);
      {sel_hi, sel_lo, df} = ~{sel_hi, sel_lo, df};
      en = 1'b1;
      repeat (40) @(negedge clk);
      check_lvl("port in init", 1'b0, data | bck | lrck);
      for (k = 0; k < 1100 && busy !== 1'b0; k++)
         @(negedge clk);
      if (m == MODE_RSVD)
         check_lvl("reserved code", 1'b1, merr);
      else
         check_mode("settings kept", exp_mode(m, d), {mode, osr, mck, ldf});
   endtask

   // ----------------------------------------
   // monitors: oldest note against each result
   // ----------------------------------------
   always @(negedge clk) begin
      busy_q <= busy;
      if (busy === 1'b1 && busy_q === 1'b0 && mq.size() > 0)
         check_mode("mode outputs", mq.pop_front(), {mode, osr, mck, ldf});
   end

   initial begin
      logic [51:0] n;
      logic [63:0] f;
      logic [23:0] dm;
      logic [15:0] nc;
      logic lp, bp;
      lp = 1'b1;
      forever begin
         @(negedge clk);
         if (lrck === 1'b1 && lp === 1'b0 && wq.size() > 0) begin
            n = wq.pop_front();
            dm = drop_mask(n[49:48]);
            nc = 16'h0000;
            f = {63'h0, data};
            check_lvl("sample take", 1'b1, take);
            for (int i = 1; i < 64; i++) begin
               do begin
                  bp = bck;
                  @(negedge clk);
                  nc++;
               end while (!(bp === 1'b1 && bck === 1'b0));
               f = {f[62:0], data};
            end
            check_cnt("frame length", bck_len(n[51:50]), nc);
            if (dm == 24'h000000) begin
               check_word("left slot", n[47:24], f[63:40]);
               check_word("right slot", n[23:0], f[31:8]);
            end else begin
               check_word("left low bits", 24'h000000, f[63:40] & dm);
               check_word("right low bits", 24'h000000, f[31:8] & dm);
               check_lvl("left dither", 1'b1, within_lsb(n[47:24], f[63:40], dm));
               check_lvl("right dither", 1'b1, within_lsb(n[23:0], f[31:8], dm));
            end
            check_word("slot padding", 24'h000000, {8'h00, f[39:32], f[7:0]});
            words++;
         end
         lp = lrck;
      end
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         mismatches++;
         give_verdict();
      end
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      int k;
      logic [1:0] w;
      logic [1:0] mm;
      repeat (4) @(negedge clk);
      for (int m = 0; m < 4; m++)
         for (int d = 0; d < 2; d++)
            do_reset(m[1:0], d[0], WL_24);
      // samples held while a frame is watched; low bits must be cleared when reduced
      // every word length code and every legal mode carries at least one frame
      for (int i = 0; i < 6; i++) begin
         w = (i < 4) ? (i[0] ? WL_16 : WL_24) : (i[0] ? WL_20 : WL_18);
         mm = (i < 2) ? MODE_NORMAL : ((i < 4) ? MODE_QUAD : MODE_DOUBLE);
         seed = lfsr(seed);
         left = seed[23:0];
         seed = lfsr(seed);
         right = seed[23:0];
         do_reset(mm, 1'b0, w);
         wq.push_back({mm, w, left, right});
         for (k = 0; k < 3000 && words < i + 1; k++)
            @(negedge clk);
         en = 1'b0;
         repeat (2) @(negedge clk);
         check_lvl("port disabled", 1'b0, data | bck | lrck);
      end
      give_verdict();
   end
endmodule
